// >>> lcdhi_host_mdl.sv
// Host model: 6800, 8080 or serial master on the pins.
// Assumes the bench merges the data bus from the enable.
`timescale 1ns/1ps
module lcdhi_host_mdl (
    input wire logic clk_sys_i,
    input wire logic [7:0] bus_i,
    output lcdhi_pkg::lcdhi_pins_t pin_o
);
    import lcdhi_pkg::*;
    // Straps and idle strobe levels
    task automatic cfg(input logic par, input logic s68, input logic on);
        pin_o.bus_select_strap <= par;
        pin_o.parallel_style_strap <= s68;
        pin_o.e_rd <= !(par && s68);
        pin_o.rw_wr <= par && !s68;
        pin_o.host_data_bus <= 8'h00;
        pin_o.data_cmd <= 1'b0;
        sel_chip(on);
    endtask
    task automatic sel_chip(input logic on);
        pin_o.chip_select_active_low <= !on;
        pin_o.chip_select_active_high <= on;
    endtask
    // One parallel cycle, strobe held 6 clocks
    task automatic par(input logic rd, input logic dc, input logic [7:0] d, output logic [7:0] q);
        pin_o.data_cmd <= dc;
        pin_o.host_data_bus <= rd ? ~pin_o.host_data_bus : d;
        if (pin_o.parallel_style_strap)
            pin_o.rw_wr <= rd;
        @(posedge clk_sys_i);
        if (pin_o.parallel_style_strap)
            pin_o.e_rd <= 1'b1;
        else if (rd)
            pin_o.e_rd <= 1'b0;
        else
            pin_o.rw_wr <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        q = bus_i;
        pin_o.e_rd <= !pin_o.parallel_style_strap;
        pin_o.rw_wr <= !pin_o.parallel_style_strap;
        repeat (6) @(posedge clk_sys_i);
    endtask
    // Serial bits MSB first, clock low between frames
    task automatic ser(input logic dc, input logic [7:0] d, input int n);
        pin_o.data_cmd <= dc;
        for (int i = 7; i > 7 - n; i--) begin
            pin_o.host_data_bus[7] <= d[i];
            repeat (4) @(posedge clk_sys_i);
            pin_o.host_data_bus[6] <= 1'b1;
            repeat (4) @(posedge clk_sys_i);
            pin_o.host_data_bus[6] <= 1'b0;
        end
        pin_o.host_data_bus[7] <= !d[8 - n];
    endtask
endmodule // lcdhi_host_mdl

// >>> lcdhi_host_port.sv
// Host port of an LCD segment/common driver: 6800, 8080 or 4-wire serial.
// Assumes all host pins are asynchronous to clk_sys_i and the host strobes are
// several system clocks long; RAM read data follows ram_rd_req_o by one clock.
`timescale 1ns/1ps
`include "lcdhi_regs.svh"

module lcdhi_host_port #(
    parameter int DATA_W = `LCDHI_BYTE_BITS
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Interface straps
    input wire logic bus_select_strap_i,
    input wire logic parallel_style_strap_i,
    // Host selects, strobes and data
    input wire logic chip_select_active_low_n_i,
    input wire logic chip_select_active_high_i,
    input wire logic data_cmd_i,
    input wire logic rw_wr_i,
    input wire logic e_rd_i,
    input wire logic [DATA_W-1:0] host_data_bus_i,
    // Read data back to the host
    output logic [DATA_W-1:0] host_data_bus_o,
    output logic host_data_bus_oe_n_o,
    // Bytes to the display RAM or command decoder
    output logic wr_valid_o,
    output lcdhi_pkg::lcdhi_wr_t wr_byte_o,
    // Display RAM fetch and status
    output logic ram_rd_req_o,
    input wire logic [DATA_W-1:0] ram_rd_data_i,
    input wire logic [DATA_W-1:0] status_i,
    // Interface in use
    output lcdhi_pkg::lcdhi_mode_t mode_o
);
    import lcdhi_pkg::*;

    // Shift one serial bit in at the bottom, MSB first
    function automatic logic [DATA_W-1:0] shift_in(input logic [DATA_W-1:0] word, input logic bit_in);
        return {word[DATA_W-2:0], bit_in};
    endfunction

    // Routing flag and byte taken from the synchronised pins
    function automatic lcdhi_wr_t capture(input lcdhi_pins_t p);
        return '{is_data: p.data_cmd, value: p.host_data_bus};
    endfunction

    // Elaboration check: the logic serves only the documented byte width
    if (DATA_W != `LCDHI_BYTE_BITS) begin : g_width_check
        $error("lcdhi_host_port: DATA_W must be 8");
    end

    // Raw pins gathered for the synchroniser
    // Every pin is asynchronous, straps included
    lcdhi_pins_t pins_raw;
    lcdhi_pins_t sync1_reg;
    lcdhi_pins_t sync2_reg;

    assign pins_raw.bus_select_strap = bus_select_strap_i;
    assign pins_raw.parallel_style_strap = parallel_style_strap_i;
    assign pins_raw.chip_select_active_low = chip_select_active_low_n_i;
    assign pins_raw.chip_select_active_high = chip_select_active_high_i;
    assign pins_raw.data_cmd = data_cmd_i;
    assign pins_raw.rw_wr = rw_wr_i;
    assign pins_raw.e_rd = e_rd_i;
    assign pins_raw.host_data_bus = host_data_bus_i;

    // Two-flop synchroniser; only the second stage is read by logic
    // Costs two clocks of latency on every pin, so host strobes must
    // stand several system clocks to be seen at all
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
        end
    end

    // Mode decode from the two straps only
    wire logic par_sel = sync2_reg.bus_select_strap;
    wire logic style_68 = sync2_reg.parallel_style_strap;
    lcdhi_mode_t mode;
    assign mode = !par_sel ? LCDHI_MODE_SERIAL
                : (style_68 ? LCDHI_MODE_6800 : LCDHI_MODE_8080);
    lcdhi_mode_t mode_reg;

    // Mode output from a flop; reset matches straps synchronised as low
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_reg <= LCDHI_MODE_SERIAL;
        end else begin
            mode_reg <= mode;
        end
    end
    assign mode_o = mode_reg;

    // One flag per interface
    wire logic is_68 = (mode == LCDHI_MODE_6800);
    wire logic is_80 = (mode == LCDHI_MODE_8080);
    wire logic is_ser = (mode == LCDHI_MODE_SERIAL);

    // Chip selected only with active-low select low and active-high select high
    // Both selects pass the same synchroniser, so they change together
    wire logic chip_sel = !sync2_reg.chip_select_active_low
                        && sync2_reg.chip_select_active_high;

    // Strobe decode per parallel style
    // In 6800 style the direction must hold while enable stands: a flip
    // mid-strobe would end a read and start a write. In 8080 style both
    // strobes low at once is taken as a read.
    wire logic rd_68 = is_68 && sync2_reg.e_rd && sync2_reg.rw_wr;
    wire logic wr_68 = is_68 && sync2_reg.e_rd && !sync2_reg.rw_wr;
    wire logic rd_80 = is_80 && !sync2_reg.e_rd;
    wire logic wr_80 = is_80 && !sync2_reg.rw_wr;
    wire logic rd_strobe = chip_sel && (rd_68 || rd_80);
    wire logic wr_strobe = chip_sel && (wr_68 || wr_80) && !rd_strobe;

    // Parallel cycle state and read pipeline
    // A RAM read returns the latch filled by the previous RAM read and
    // then fetches the next byte; so the first RAM read after reset or an
    // address change shows stale data and must be thrown away by the host.
    // Status reads bypass the latch and fetch nothing.
    lcdhi_state_t state_reg, state_next;
    logic [DATA_W-1:0] dout_reg, dout_next;
    logic [DATA_W-1:0] rd_latch_reg;
    logic rd_is_ram_reg, rd_is_ram_next;
    logic ram_req_reg, ram_req_next;
    logic ram_fill_reg;
    lcdhi_wr_t hold_reg, hold_next;

    // Serial shifter
    // Edges of the serial clock are found by sampling it on the system
    // clock; a byte cut short by deselect is dropped
    logic [DATA_W-1:0] shift_reg, shift_next;
    logic [2:0] bit_cnt_reg, bit_cnt_next;
    logic sck_prev_reg;
    wire logic sck = sync2_reg.host_data_bus[`LCDHI_SCK_BIT];
    wire logic sda = sync2_reg.host_data_bus[`LCDHI_SDA_BIT];
    wire logic sck_rise = is_ser && chip_sel && sck && !sck_prev_reg;
    wire logic ser_last = sck_rise && (bit_cnt_reg == `LCDHI_SER_CNT_LAST);

    // Byte output
    // One pulse per byte; the byte stands until the next pulse or a parallel write aborted by deselect
    logic wr_valid_reg, wr_valid_next;
    lcdhi_wr_t wr_reg, wr_next;

    // Parallel cycle sequencing, read data select and write capture
    always_comb begin
        state_next = state_reg;
        dout_next = dout_reg;
        rd_is_ram_next = rd_is_ram_reg;
        ram_req_next = 1'b0;
        hold_next = hold_reg;
        wr_valid_next = 1'b0;
        wr_next = wr_reg;
        unique case (state_reg)
            LCDHI_ST_IDLE: begin
                if (rd_strobe) begin
                    state_next = LCDHI_ST_READ;
                    rd_is_ram_next = sync2_reg.data_cmd;
                    // Pipelined latch: first RAM read after setup is stale
                    dout_next = sync2_reg.data_cmd ? rd_latch_reg : status_i;
                end else if (wr_strobe) begin
                    state_next = LCDHI_ST_WRITE;
                    hold_next = capture(sync2_reg);
                end
            end
            LCDHI_ST_READ: begin
                if (!rd_strobe) begin
                    state_next = LCDHI_ST_IDLE;
                    ram_req_next = rd_is_ram_reg && chip_sel;
                end
            end
            LCDHI_ST_WRITE: begin
                if (wr_strobe) begin
                    // Keep the latest bus value while the strobe stands
                    hold_next = capture(sync2_reg);
                end else begin
                    state_next = LCDHI_ST_IDLE;
                    // Deselect during the strobe aborts the write
                    wr_valid_next = chip_sel;
                    wr_next = hold_reg;
                end
            end
            default: begin
                // Unused state code: fall back to idle
                state_next = LCDHI_ST_IDLE;
            end
        endcase
        // Serial byte delivered on the eighth rising clock
        if (ser_last) begin
            wr_valid_next = 1'b1;
            wr_next.is_data = sync2_reg.data_cmd;
            wr_next.value = shift_in(shift_reg, sda);
        end
    end

    // Serial shift and bit count, cleared while deselected or not serial
    // Clearing on deselect keeps the next selection on a byte boundary
    // even when the host gave up half way through a byte
    always_comb begin
        shift_next = shift_reg;
        bit_cnt_next = bit_cnt_reg;
        if (!is_ser || !chip_sel) begin
            shift_next = `LCDHI_BYTE_RST;
            bit_cnt_next = `LCDHI_SER_CNT_RST;
        end else if (sck_rise) begin
            shift_next = shift_in(shift_reg, sda);
            bit_cnt_next = bit_cnt_reg + 3'h1;
        end
    end

    // Parallel state registers
    // The held byte is only committed when the strobe ends selected
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= LCDHI_ST_IDLE;
            dout_reg <= `LCDHI_BYTE_RST;
            rd_is_ram_reg <= 1'b0;
            ram_req_reg <= 1'b0;
            hold_reg <= '0;
        end else begin
            state_reg <= state_next;
            dout_reg <= dout_next;
            rd_is_ram_reg <= rd_is_ram_next;
            ram_req_reg <= ram_req_next;
            hold_reg <= hold_next;
        end
    end

    // RAM read latch, refilled one clock after each request
    // The RAM side must answer in exactly one clock; a slower RAM
    // would leave the latch with the wrong byte
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ram_fill_reg <= 1'b0;
            rd_latch_reg <= `LCDHI_BYTE_RST;
        end else begin
            ram_fill_reg <= ram_req_reg;
            if (ram_fill_reg) begin
                rd_latch_reg <= ram_rd_data_i;
            end
        end
    end

    // Serial registers
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_reg <= `LCDHI_BYTE_RST;
            bit_cnt_reg <= `LCDHI_SER_CNT_RST;
            sck_prev_reg <= 1'b0;
        end else begin
            shift_reg <= shift_next;
            bit_cnt_reg <= bit_cnt_next;
            sck_prev_reg <= sck;
        end
    end

    // Delivered byte registers
    // Parallel and serial share them; the modes never run together
    // because the straps pick exactly one interface
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_valid_reg <= 1'b0;
            wr_reg <= '0;
        end else begin
            wr_valid_reg <= wr_valid_next;
            wr_reg <= wr_next;
        end
    end

    // Outputs; bus driven only in a selected read cycle
    // The enable drops in the same clock the synchronised strobe does,
    // so the bus is released as soon as the read is seen to end
    assign host_data_bus_o = dout_reg;
    assign host_data_bus_oe_n_o = !((state_reg == LCDHI_ST_READ) && rd_strobe);
    assign wr_valid_o = wr_valid_reg;
    assign wr_byte_o = wr_reg;
    assign ram_rd_req_o = ram_req_reg;

endmodule // lcdhi_host_port

// >>> lcdhi_host_port_sva.sv
// Checker for the host port outputs.
// Assumes a bind onto lcdhi_host_port; one clock domain.
`timescale 1ns/1ps
module lcdhi_host_port_sva (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic bus_select_strap_i,
    input wire logic parallel_style_strap_i,
    input wire logic chip_select_active_low_n_i,
    input wire logic rw_wr_i,
    input wire logic e_rd_i,
    input wire logic host_data_bus_oe_n_o,
    input wire logic wr_valid_o,
    input wire logic ram_rd_req_o,
    input wire lcdhi_pkg::lcdhi_mode_t mode_o
);
    import lcdhi_pkg::*;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // Straps select the interface
    ser_mode_a: assert property ((!bus_select_strap_i) [*4] |-> mode_o == LCDHI_MODE_SERIAL)
        else $error("serial mode missed");
    par_mode_a: assert property (bus_select_strap_i [*4] |-> mode_o != LCDHI_MODE_SERIAL)
        else $error("parallel mode missed");
    style_sel_a: assert property ((bus_select_strap_i && $stable(parallel_style_strap_i)) [*4]
        |-> mode_o == (parallel_style_strap_i ? LCDHI_MODE_6800 : LCDHI_MODE_8080))
        else $error("style wrong");
    // Bus direction and strobes
    ser_wo_a: assert property (mode_o == LCDHI_MODE_SERIAL |-> host_data_bus_oe_n_o)
        else $error("serial drove bus");
    desel_off_a: assert property (chip_select_active_low_n_i [*4] |-> host_data_bus_oe_n_o)
        else $error("deselected drive");
    wr_nodrv_a: assert property (wr_valid_o |-> host_data_bus_oe_n_o)
        else $error("drive on write");
    rd_68_a: assert property ($fell(host_data_bus_oe_n_o) && mode_o == LCDHI_MODE_6800
        |-> $past(rw_wr_i, 2) && $past(e_rd_i, 2))
        else $error("bad 6800 read");
    rd_80_a: assert property ($fell(host_data_bus_oe_n_o) && mode_o == LCDHI_MODE_8080
        |-> !$past(e_rd_i, 2))
        else $error("bad 8080 read");
    wr_pulse_a: assert property (wr_valid_o |=> !wr_valid_o)
        else $error("long write pulse");
    fetch_one_a: assert property (ram_rd_req_o |=> !ram_rd_req_o && host_data_bus_oe_n_o)
        else $error("bad fetch");
    cover property (wr_valid_o && mode_o == LCDHI_MODE_SERIAL);
    cover property ($fell(host_data_bus_oe_n_o) && mode_o == LCDHI_MODE_8080);
    cover property (ram_rd_req_o);
endmodule // lcdhi_host_port_sva

// >>> lcdhi_host_port_tb.sv
// Bench: reads and writes in both parallel modes, serial bytes in serial mode.
// Assumes the model and checker are compiled first.
`timescale 1ns/1ps
module lcdhi_host_port_tb;
    import lcdhi_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] ram_d = 8'h00;
    logic [7:0] stat = 8'h00;
    logic [7:0] wr_cnt = 8'h00;
    logic [15:0] lfsr_reg = 16'he4b1;
    logic [7:0] bus_o, bus_w, q, d, n0;
    logic oe_n, wr_valid, rd_req;
    lcdhi_pins_t pin;
    lcdhi_wr_t wr_byte, last_wr;
    lcdhi_mode_t mode;
    int fail_count = 0;
    int compares = 0;
    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    // Device drives the bus only while enabled
    assign bus_w = oe_n ? pin.host_data_bus : bus_o;
    lcdhi_host_mdl mdl (.clk_sys_i(clk_sys_i), .bus_i(bus_w), .pin_o(pin));
    lcdhi_host_port dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .bus_select_strap_i(pin.bus_select_strap), .parallel_style_strap_i(pin.parallel_style_strap),
        .chip_select_active_low_n_i(pin.chip_select_active_low),
        .chip_select_active_high_i(pin.chip_select_active_high), .data_cmd_i(pin.data_cmd),
        .rw_wr_i(pin.rw_wr), .e_rd_i(pin.e_rd), .host_data_bus_i(bus_w), .host_data_bus_o(bus_o),
        .host_data_bus_oe_n_o(oe_n), .wr_valid_o(wr_valid), .wr_byte_o(wr_byte),
        .ram_rd_req_o(rd_req), .ram_rd_data_i(ram_d), .status_i(stat), .mode_o(mode));
    // Last delivered byte and count
    always @(posedge clk_sys_i) begin
        if (wr_valid === 1'b1) begin
            last_wr <= wr_byte;
            wr_cnt <= wr_cnt + 8'h01;
        end
    end
    function automatic lcdhi_wr_t exp_wr(input logic dc, input logic [7:0] v);
        return '{is_data: dc, value: v};
    endfunction
    task automatic rnd(output logic [7:0] v);
        lfsr_reg = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
        v = lfsr_reg[7:0];
    endtask
    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_wr(input lcdhi_wr_t g, input lcdhi_wr_t e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic close_out;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        fail_count++;
        close_out();
    end
    // One pass per mode, reset between
    initial begin
        for (int m = 0; m < 3; m++) begin
            rst_n_i <= 1'b0;
            mdl.cfg(m != 2, m == 0, 1'b1);
            repeat (5) @(posedge clk_sys_i);
            rst_n_i <= 1'b1;
            repeat (4) @(posedge clk_sys_i);
            chk_byte(8'(mode), 8'(m));
            n0 = wr_cnt;
            if (m < 2) begin
                rnd(d);
                stat <= d;
                rnd(d);
                ram_d <= d;
                mdl.par(1'b1, 1'b0, 8'h00, q);
                chk_byte(q, stat);
                mdl.par(1'b1, 1'b1, 8'h00, q);
                chk_byte(q, 8'h00);
                mdl.par(1'b1, 1'b1, 8'h00, q);
                chk_byte(q, ram_d);
                for (int i = 0; i < 4; i++) begin
                    rnd(d);
                    mdl.par(1'b0, d[0], d, q);
                    chk_wr(last_wr, exp_wr(d[0], d));
                end
                mdl.sel_chip(1'b0);
                mdl.par(1'b0, 1'b1, 8'h5a, q);
            end else begin
                mdl.ser(1'b0, 8'he2, 8);
                repeat (4) @(posedge clk_sys_i);
                chk_wr(last_wr, exp_wr(1'b0, 8'he2));
                mdl.ser(1'b1, 8'hff, 3);
                mdl.sel_chip(1'b0);
                repeat (8) @(posedge clk_sys_i);
                mdl.sel_chip(1'b1);
                repeat (8) @(posedge clk_sys_i);
                for (int i = 0; i < 3; i++) begin
                    rnd(d);
                    mdl.ser(d[1], d, 8);
                    repeat (4) @(posedge clk_sys_i);
                    chk_wr(last_wr, exp_wr(d[1], d));
                end
            end
            chk_byte(wr_cnt - n0, 8'h04);
            $display("mode %0d test done", m);
        end
        close_out();
    end
endmodule // lcdhi_host_port_tb
bind lcdhi_host_port lcdhi_host_port_sva sva_i (.*);

// >>> lcdhi_pkg.sv
// Types shared by the LCD driver host port.
// Assumes the constants header is in the include path.
`include "lcdhi_regs.svh"

package lcdhi_pkg;

    // Host interface chosen by the straps
    typedef enum logic [1:0] {
        LCDHI_MODE_6800,
        LCDHI_MODE_8080,
        LCDHI_MODE_SERIAL
    } lcdhi_mode_t;

    // Parallel cycle in progress
    typedef enum logic [1:0] {
        LCDHI_ST_IDLE,
        LCDHI_ST_READ,
        LCDHI_ST_WRITE
    } lcdhi_state_t;

    // All host-side pins, sampled together
    typedef struct packed {
        logic bus_select_strap;
        logic parallel_style_strap;
        logic chip_select_active_low;
        logic chip_select_active_high;
        logic data_cmd;
        logic rw_wr;
        logic e_rd;
        logic [`LCDHI_BYTE_BITS-1:0] host_data_bus;
    } lcdhi_pins_t;

    // One byte delivered to the display RAM or command decoder
    typedef struct packed {
        logic is_data;
        logic [`LCDHI_BYTE_BITS-1:0] value;
    } lcdhi_wr_t;

endpackage

// >>> lcdhi_regs.svh
// Constants for the LCD driver host port: bit positions, reset values, counts.
// Assumes inclusion by the host port package and module only.
`ifndef LCDHI_REGS_SVH
`define LCDHI_REGS_SVH

// Serial clock and data positions on the host data bus
`define LCDHI_SCK_BIT 6
`define LCDHI_SDA_BIT 7
// Documented byte width
`define LCDHI_BYTE_BITS 8
// Serial bit counter values
`define LCDHI_SER_CNT_RST 3'h0
`define LCDHI_SER_CNT_LAST 3'h7
// Reset values of the data paths
`define LCDHI_BYTE_RST 8'h00

`endif
